/* File: core/scq_top.sv */
// Status condition, event and enable registers with a filtered error queue
//
// The plain strobed port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_top
  import scq_pkg::*;
#(
  parameter int DEPTH  = `SCQ_QUEUE_DEPTH,
  parameter int CODE_N = `SCQ_CODE_N
) (
  input  wire logic                   i_core_clk,
  input  wire logic                   i_nrst,
  input  wire logic [`SCQ_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]            i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [31:0]            o_rdata,
  input  wire logic [`SCQ_REG_W-1:0]  i_meas_cond,
  input  wire logic [`SCQ_REG_W-1:0]  i_ques_cond,
  input  wire logic [`SCQ_REG_W-1:0]  i_oper_cond,
  input  wire logic                   i_trace_buffer_full_flag,
  input  wire logic                   i_msg_valid,
  input  wire logic [`SCQ_REG_W-1:0]  i_msg_code,
  output logic                        o_meas_summary,
  output logic                        o_ques_summary,
  output logic                        o_oper_summary,
  output logic                        o_queue_not_empty,
  output logic                        o_queue_overflow
);
  localparam int SETS  = int'(SCQ_SET_N);
  localparam int CNT_W = $clog2(DEPTH + 1);

  localparam logic [`SCQ_ADDR_W-1:0] COND_A [SETS] = '{
    `SCQ_A_MEAS_COND, `SCQ_A_QUES_COND, `SCQ_A_OPER_COND
  };
  localparam logic [`SCQ_ADDR_W-1:0] EVENT_A [SETS] = '{
    `SCQ_A_MEAS_EVENT, `SCQ_A_QUES_EVENT, `SCQ_A_OPER_EVENT
  };
  localparam logic [`SCQ_ADDR_W-1:0] ENABLE_A [SETS] = '{
    `SCQ_A_MEAS_ENABLE, `SCQ_A_QUES_ENABLE, `SCQ_A_OPER_ENABLE
  };
  localparam scq_word_t BFL_MASK = scq_word_t'(1) << `SCQ_BFL_BIT;

  // Live inputs from the measurement side
  scq_word_t cond_raw       [SETS];
  scq_word_t cond_sync1_reg [SETS];
  scq_word_t cond_reg       [SETS];
  scq_word_t cond_live      [SETS];
  scq_word_t cond_prev_reg  [SETS];
  logic      bfl_sync1_reg;
  logic      bfl_reg;

  // Event and enable state
  scq_word_t event_reg      [SETS];
  scq_word_t event_next     [SETS];
  scq_word_t enable_reg     [SETS];
  scq_word_t enable_next    [SETS];
  logic      summary_reg    [SETS];

  // Bus decode
  logic      wr_preset;
  logic      rd_queue;
  logic      wr_clear;
  logic      wr_filt_start;
  logic      wr_filt_add;
  logic      wr_filt_remove;
  logic      wr_filt_select;
  scq_code_t filt_select_reg;
  logic [31:0] rdata_next;
  logic [31:0] rdata_reg;

  // Queue status flops for the outputs
  logic      not_empty_reg;
  logic      overflow_reg;

  scq_if #(.CNT_W(CNT_W)) link ();

  assign cond_raw[int'(SCQ_SET_MEAS)] = i_meas_cond;
  assign cond_raw[int'(SCQ_SET_QUES)] = i_ques_cond;
  assign cond_raw[int'(SCQ_SET_OPER)] = i_oper_cond;

  // Trace buffer full flag crosses in from the pin
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      bfl_sync1_reg <= 1'b0;
      bfl_reg       <= 1'b0;
    end else begin
      bfl_sync1_reg <= i_trace_buffer_full_flag;
      bfl_reg       <= bfl_sync1_reg;
    end
  end

  // Single-cycle decode of the command strobes
  assign wr_preset      = i_wr && (i_addr == `SCQ_A_PRESET);
  assign wr_clear       = i_wr && (i_addr == `SCQ_A_QUEUE_CLEAR);
  assign wr_filt_start  = i_wr && (i_addr == `SCQ_A_FILT_START);
  assign wr_filt_add    = i_wr && (i_addr == `SCQ_A_FILT_ADD);
  assign wr_filt_remove = i_wr && (i_addr == `SCQ_A_FILT_REMOVE);
  assign wr_filt_select = i_wr && (i_addr == `SCQ_A_FILT_SELECT);
  assign rd_queue       = i_rd && ((i_addr == `SCQ_A_QUEUE_NEXT) ||
                                   (i_addr == `SCQ_A_SYS_ERROR));

  // Per-set condition, event, enable and summary logic
  for (genvar s = 0; s < SETS; s++) begin : g_set
    logic rd_event;
    logic wr_enable;

    assign rd_event  = i_rd && (i_addr == EVENT_A[s]);
    assign wr_enable = i_wr && (i_addr == ENABLE_A[s]);

    // Two-stage capture of the live status pins
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst) begin
        cond_sync1_reg[s] <= `SCQ_COND_RST;
        cond_reg[s]       <= `SCQ_COND_RST;
      end else begin
        cond_sync1_reg[s] <= cond_raw[s];
        cond_reg[s]       <= cond_sync1_reg[s];
      end
    end

    // Measurement set also reflects the trace buffer state
    if (s == int'(SCQ_SET_MEAS)) begin : g_bfl
      assign cond_live[s] = cond_reg[s] | (bfl_reg ? BFL_MASK : '0);
    end else begin : g_plain
      assign cond_live[s] = cond_reg[s];
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
        cond_prev_reg[s] <= `SCQ_COND_RST;
      else
        cond_prev_reg[s] <= cond_live[s];
    end

    // Rising condition latches; a rise in the reading cycle survives the read
    always_comb begin
      event_next[s] = rd_event ? '0 : event_reg[s];
      event_next[s] = event_next[s] | (cond_live[s] & ~cond_prev_reg[s]);
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
        event_reg[s] <= `SCQ_EVENT_RST;
      else
        event_reg[s] <= event_next[s];
    end

    always_comb begin
      if (wr_preset)
        enable_next[s] = '0;
      else if (wr_enable)
        enable_next[s] = i_wdata[`SCQ_REG_W-1:0];
      else
        enable_next[s] = enable_reg[s];
    end

    always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
        enable_reg[s] <= `SCQ_ENABLE_RST;
      else
        enable_reg[s] <= enable_next[s];
    end

    // Only unmasked events reach this set's own summary output
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
        summary_reg[s] <= 1'b0;
      else
        summary_reg[s] <= |(event_reg[s] & enable_reg[s]);
    end
  end

  // Code chosen for the filter query registers
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst)
      filt_select_reg <= '0;
    else if (wr_filt_select)
      filt_select_reg <= scq_code_t'(i_wdata[`SCQ_REG_W-1:0]);
  end

  // Queue and filter control toward the submodules
  assign link.pop         = rd_queue;
  assign link.clear       = wr_clear;
  assign link.probe_msg   = scq_code_t'(i_msg_code);
  assign link.push        = i_msg_valid && link.msg_enabled;
  assign link.push_code   = scq_code_t'(i_msg_code);
  assign link.filt_start  = wr_filt_start;
  assign link.filt_add    = wr_filt_add;
  assign link.filt_remove = wr_filt_remove;
  assign link.range_lo    = scq_code_t'(i_wdata[`SCQ_RANGE_LO_LSB +: `SCQ_REG_W]);
  assign link.range_hi    = scq_code_t'(i_wdata[`SCQ_RANGE_HI_LSB +: `SCQ_REG_W]);
  assign link.probe_query = filt_select_reg;

  scq_err_fifo #(
    .DEPTH (DEPTH),
    .CNT_W (CNT_W)
  ) u_fifo (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .q          (link.fifo)
  );

  scq_code_filter #(
    .CODE_N (CODE_N)
  ) u_filter (
    .i_core_clk (i_core_clk),
    .i_nrst     (i_nrst),
    .f          (link.filt)
  );

  // Read mux; data stand only in the cycle after the strobe
  always_comb begin
    rdata_next = '0;
    if (i_rd) begin
      for (int s = 0; s < SETS; s++) begin
        if (i_addr == COND_A[s])
          rdata_next = {16'h0000, cond_live[s]};
        if (i_addr == EVENT_A[s])
          rdata_next = {16'h0000, event_reg[s]};
        if (i_addr == ENABLE_A[s])
          rdata_next = {16'h0000, enable_reg[s]};
      end
      case (i_addr)
        `SCQ_A_QUEUE_NEXT,
        `SCQ_A_SYS_ERROR: begin
          rdata_next = 32'(signed'(link.head_code));
        end
        `SCQ_A_FILT_SELECT: begin
          rdata_next = 32'(signed'(filt_select_reg));
        end
        `SCQ_A_FILT_EN_Q: begin
          rdata_next = {31'h0, link.query_enabled};
        end
        `SCQ_A_FILT_DIS_Q: begin
          rdata_next = {31'h0, ~link.query_enabled};
        end
        `SCQ_A_QUEUE_STAT: begin
          rdata_next[CNT_W-1:0]          = link.count;
          rdata_next[`SCQ_STAT_EMPTY_BIT] = (link.count == '0);
          rdata_next[`SCQ_STAT_OVF_BIT]   = link.ovf_held;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  // Queue state shown on the pins
  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      not_empty_reg <= 1'b0;
      overflow_reg  <= 1'b0;
    end else begin
      not_empty_reg <= (link.count != '0);
      overflow_reg  <= link.ovf_held;
    end
  end

  // Preset leaves events, conditions, queue and filter alone
  assign o_rdata           = rdata_reg;
  assign o_meas_summary    = summary_reg[int'(SCQ_SET_MEAS)];
  assign o_ques_summary    = summary_reg[int'(SCQ_SET_QUES)];
  assign o_oper_summary    = summary_reg[int'(SCQ_SET_OPER)];
  assign o_queue_not_empty = not_empty_reg;
  assign o_queue_overflow  = overflow_reg;
endmodule

/* File: core/scq_regs.svh */
// Register offsets, field positions, reset values and codes of the status block
`ifndef SCQ_REGS_SVH
`define SCQ_REGS_SVH
// What this block does
// - Measurement, questionable and operation sets each have a live condition register.
// - The standard event set has no condition register.
// - A condition query returns the raw register bits for decimal reporting.
// - Measurement condition bit 9 reads set while the trace buffer is full.
// - Status preset clears the three event enable registers to zero.
// - Status preset touches no other register.
// - Queue reads return the oldest message and remove it.
// - The error queue holds at most ten messages.
// - On filling, the last slot holds overflow code 350.
// - After power-up the error queue is empty.
// - Reading an empty queue returns code 0, no error.
// - Codes are signed; negative for standard messages, positive for maker messages.
// - A queue read query returns the oldest queued message.
// - Queue-next and system error queries pop the same queue identically.
// - Queue clear discards every stored message.
// - After power-up error codes are enabled and status codes disabled.
// - Enable command disables all codes, then enables only listed ones.
// - Enable query reports which codes are enabled.
// - Lists may be single codes, several codes, ranges, or mixtures.
// - An enable with an empty list blocks every code.
// - Disable blocks listed codes; disable query reports disabled codes.
// - Cleared enable bit masks its event from the summary; set bit passes it.
`define SCQ_ADDR_W         8
`define SCQ_REG_W          16
`define SCQ_A_MEAS_COND    8'h00
`define SCQ_A_QUES_COND    8'h04
`define SCQ_A_OPER_COND    8'h08
`define SCQ_A_MEAS_EVENT   8'h0c
`define SCQ_A_QUES_EVENT   8'h10
`define SCQ_A_OPER_EVENT   8'h14
`define SCQ_A_MEAS_ENABLE  8'h18
`define SCQ_A_QUES_ENABLE  8'h1c
`define SCQ_A_OPER_ENABLE  8'h20
`define SCQ_A_PRESET       8'h24
`define SCQ_A_QUEUE_NEXT   8'h28
`define SCQ_A_SYS_ERROR    8'h2c
`define SCQ_A_QUEUE_CLEAR  8'h30
`define SCQ_A_FILT_START   8'h34
`define SCQ_A_FILT_ADD     8'h38
`define SCQ_A_FILT_REMOVE  8'h3c
`define SCQ_A_FILT_SELECT  8'h40
`define SCQ_A_FILT_EN_Q    8'h44
`define SCQ_A_FILT_DIS_Q   8'h48
`define SCQ_A_QUEUE_STAT   8'h4c
`define SCQ_RANGE_LO_LSB   0
`define SCQ_RANGE_HI_LSB   16
`define SCQ_STAT_EMPTY_BIT 4
`define SCQ_STAT_OVF_BIT   5
`define SCQ_BFL_BIT        9
`define SCQ_COND_RST       16'h0000
`define SCQ_EVENT_RST      16'h0000
`define SCQ_ENABLE_RST     16'h0000
`define SCQ_QUEUE_DEPTH    10
`define SCQ_OVERFLOW_CODE  16'h015e
`define SCQ_NO_ERROR_CODE  16'h0000
`define SCQ_STATUS_MIN     16'h0064
`define SCQ_CODE_N         1024
`endif

/* File: core/scq_pkg.sv */
// Types shared by the status and error queue modules
`include "scq_regs.svh"
package scq_pkg;
  typedef logic signed [`SCQ_REG_W-1:0] scq_code_t;
  typedef logic [`SCQ_REG_W-1:0]        scq_word_t;
  typedef enum {SCQ_SET_MEAS, SCQ_SET_QUES, SCQ_SET_OPER, SCQ_SET_N} scq_set_t;
endpackage

/* File: core/scq_if.sv */
// Carrier between the top, the error queue and the code filter
`timescale 1ns/1ps
interface scq_if
  import scq_pkg::*;
#(
  parameter int CNT_W = 4
);
  logic             push;
  scq_code_t        push_code;
  logic             pop;
  logic             clear;
  scq_code_t        head_code;
  logic [CNT_W-1:0] count;
  logic             ovf_held;
  logic             filt_start;
  logic             filt_add;
  logic             filt_remove;
  scq_code_t        range_lo;
  scq_code_t        range_hi;
  scq_code_t        probe_msg;
  scq_code_t        probe_query;
  logic             msg_enabled;
  logic             query_enabled;
  modport fifo (input push, push_code, pop, clear, output head_code, count, ovf_held);
  modport filt (input filt_start, filt_add, filt_remove, range_lo, range_hi, probe_msg, probe_query,
                output msg_enabled, query_enabled);
  modport ctrl (output push, push_code, pop, clear, filt_start, filt_add, filt_remove, range_lo,
                range_hi, probe_msg, probe_query,
                input head_code, count, ovf_held, msg_enabled, query_enabled);
endinterface

/* File: core/scq_err_fifo.sv */
// Ten-entry error queue with overflow marker and no-error answer
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_err_fifo
  import scq_pkg::*;
#(
  parameter int DEPTH = `SCQ_QUEUE_DEPTH,
  parameter int CNT_W = 4
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  scq_if.fifo       q
);
  scq_code_t        mem [DEPTH];
  logic [CNT_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] wr_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             pop_ok;
  logic [CNT_W-1:0] eff_count;
  logic             accept;
  scq_code_t        store_code;

  function automatic logic [CNT_W-1:0] wrap_inc(input logic [CNT_W-1:0] p);
    wrap_inc = (p == CNT_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign pop_ok     = q.pop && (count_reg != '0);
  assign eff_count  = count_reg - CNT_W'(pop_ok);
  assign accept     = q.push && (eff_count < CNT_W'(DEPTH));
  assign store_code = (eff_count == CNT_W'(DEPTH - 1)) ? `SCQ_OVERFLOW_CODE : q.push_code;

  always_ff @(posedge i_core_clk) begin
    if (!i_nrst) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= '0;
      count_reg  <= '0;
    end else if (q.clear) begin
      rd_ptr_reg <= '0;
      wr_ptr_reg <= q.push ? CNT_W'(1) : '0;
      count_reg  <= q.push ? CNT_W'(1) : '0;
    end else begin
      if (pop_ok)
        rd_ptr_reg <= wrap_inc(rd_ptr_reg);
      if (accept)
        wr_ptr_reg <= wrap_inc(wr_ptr_reg);
      count_reg <= eff_count + CNT_W'(accept);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (q.clear && q.push)
      mem[0] <= q.push_code;
    else if (!q.clear && accept)
      mem[wr_ptr_reg] <= store_code;
  end

  assign q.head_code = (count_reg == '0) ? `SCQ_NO_ERROR_CODE : mem[rd_ptr_reg];
  assign q.count     = count_reg;
  assign q.ovf_held  = (count_reg == CNT_W'(DEPTH));
endmodule

/* File: core/scq_code_filter.sv */
// Per-code admission map for the error queue
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_code_filter
  import scq_pkg::*;
#(
  parameter int CODE_N = `SCQ_CODE_N
) (
  input  wire logic i_core_clk,
  input  wire logic i_nrst,
  scq_if.filt       f
);
  localparam int IDX_W = $clog2(CODE_N);
  logic [CODE_N-1:0] en_reg;
  scq_word_t         off_msg;
  scq_word_t         off_query;

  for (genvar i = 0; i < CODE_N; i++) begin : g_code
    localparam scq_code_t CODE = scq_code_t'(i - CODE_N / 2);
    logic hit;
    assign hit = (CODE >= f.range_lo && CODE <= f.range_hi) ||
                 (CODE >= f.range_hi && CODE <= f.range_lo);
    always_ff @(posedge i_core_clk) begin
      if (!i_nrst)
        en_reg[i] <= (CODE < scq_code_t'(`SCQ_STATUS_MIN));
      else if (f.filt_start)
        en_reg[i] <= 1'b0;
      else if (f.filt_add && hit)
        en_reg[i] <= 1'b1;
      else if (f.filt_remove && hit)
        en_reg[i] <= 1'b0;
    end
  end

  assign off_msg         = scq_word_t'(f.probe_msg + scq_code_t'(CODE_N / 2));
  assign off_query       = scq_word_t'(f.probe_query + scq_code_t'(CODE_N / 2));
  assign f.msg_enabled   = (off_msg < scq_word_t'(CODE_N)) && en_reg[off_msg[IDX_W-1:0]];
  assign f.query_enabled = (off_query < scq_word_t'(CODE_N)) && en_reg[off_query[IDX_W-1:0]];
endmodule

/* File: dv/scq_top_props.sv */
// Concurrent checks on the status and error queue top ports
`timescale 1ns/1ps
`include "scq_regs.svh"
module scq_top_chk
  import scq_pkg::*;
#(
  parameter int DEPTH = 10
) (
  input wire logic                   i_core_clk,
  input wire logic                   i_nrst,
  input wire logic [`SCQ_ADDR_W-1:0] i_addr,
  input wire logic [31:0]            i_wdata,
  input wire logic                   i_wr,
  input wire logic                   i_rd,
  input wire logic [31:0]            o_rdata,
  input wire logic [`SCQ_REG_W-1:0]  i_ques_cond,
  input wire logic                   i_trace_buffer_full_flag,
  input wire logic                   i_msg_valid,
  input wire logic                   o_meas_summary,
  input wire logic                   o_queue_not_empty
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_preset;
    i_wr && i_addr == 8'h24;
  endsequence
  sequence s_rd_meas_en;
    i_rd && i_addr == 8'h18;
  endsequence
  sequence s_meas_en_zero;
    i_wr && i_addr == 8'h18 && i_wdata[15:0] == 16'h0000;
  endsequence
  chk_rdata_idle_zero: assert property (!i_rd |=> o_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  chk_full_bit_set: assert property ((i_trace_buffer_full_flag && i_nrst)[*4] ##0 (i_rd && i_addr == 8'h00)
    |=> o_rdata[`SCQ_BFL_BIT]) else $error("buffer full bit not set");
  chk_cond_live: assert property (($stable(i_ques_cond) && i_nrst)[*3] ##0 (i_rd && i_addr == 8'h04)
    |=> o_rdata == {16'h0000, $past(i_ques_cond)}) else $error("condition read not live");
  chk_empty_no_error: assert property (i_rd && i_addr == 8'h28 && !o_queue_not_empty && !i_msg_valid
    && !$past(i_msg_valid) |=> o_rdata == 32'h0000_0000) else $error("empty queue read not zero");
  chk_preset_clears: assert property (s_preset ##1 !i_wr ##1 s_rd_meas_en |=> o_rdata == 32'h0000_0000)
    else $error("enable not cleared by preset");
  chk_enable_rw: assert property (i_wr && i_addr == 8'h1c ##1 !i_wr ##1 i_rd && i_addr == 8'h1c
    |=> o_rdata == {16'h0000, $past(i_wdata[15:0], 3)}) else $error("enable readback wrong");
  chk_mask_summary: assert property (s_meas_en_zero ##1 !(i_wr && i_addr == 8'h18) |=> !o_meas_summary)
    else $error("masked summary set");
  chk_clear_empties: assert property ((i_wr && i_addr == 8'h30 && !i_msg_valid) ##1 !i_msg_valid
    |=> !o_queue_not_empty) else $error("queue not empty after clear");
  chk_stat_coherent: assert property (i_rd && i_addr == 8'h4c |=> o_rdata[3:0] <= DEPTH
    && o_rdata[4] == (o_rdata[3:0] == 4'h0) && o_rdata[5] == (o_rdata[3:0] == DEPTH) && o_rdata[31:6] == 26'h0)
    else $error("queue status incoherent");
endmodule

bind scq_top scq_top_chk #(.DEPTH(DEPTH)) scq_top_chk_inst (.i_core_clk(i_core_clk), .i_nrst(i_nrst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ques_cond(i_ques_cond),
  .i_trace_buffer_full_flag(i_trace_buffer_full_flag), .i_msg_valid(i_msg_valid),
  .o_meas_summary(o_meas_summary), .o_queue_not_empty(o_queue_not_empty));

/* File: dv/scq_host_model.sv */
// Host side model issuing register reads and writes
`timescale 1ns/1ps
module scq_host_model (
  input  wire logic        i_core_clk,
  output logic [7:0]       o_addr,
  output logic [31:0]      o_wdata,
  output logic             o_wr,
  output logic             o_rd,
  input  wire logic [31:0] i_rdata
);
  initial begin
    o_addr = 8'h00;
    o_wdata = 32'h0000_0000;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end
  task automatic write(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_core_clk);
    o_wr <= 1'b0;
    o_wdata <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_core_clk);
    o_rd <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask
  // Range or single code, bounds in either order
  task automatic list_item(input logic [7:0] a, input logic [15:0] lo, input logic [15:0] hi);
    write(a, {hi, lo});
  endtask
endmodule

/* File: dv/tb_scq_top.sv */
// Self-checking bench for the status and error queue top
`timescale 1ns/1ps
`include "scq_regs.svh"
module tb_scq_top import scq_pkg::*;;
  logic        core_clk, nrst, wr, rd, trace_buffer_full_flag, msg_valid;
  logic [7:0]  addr;
  logic [31:0] wdata, rdata;
  logic [15:0] meas_cond, ques_cond, oper_cond, msg_code;
  logic        meas_summary, ques_summary, oper_summary, q_not_empty, q_overflow;
  int          err_count = 0;
  int          samples_checked = 0;
  logic [31:0] exp_q[$];

  scq_top scq_top_inst (.i_core_clk(core_clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
    .i_rd(rd), .o_rdata(rdata), .i_meas_cond(meas_cond), .i_ques_cond(ques_cond), .i_oper_cond(oper_cond),
    .i_trace_buffer_full_flag(trace_buffer_full_flag), .i_msg_valid(msg_valid), .i_msg_code(msg_code),
    .o_meas_summary(meas_summary), .o_ques_summary(ques_summary), .o_oper_summary(oper_summary),
    .o_queue_not_empty(q_not_empty), .o_queue_overflow(q_overflow));
  scq_host_model host_inst (.i_core_clk(core_clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
    .i_rdata(rdata));

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    host_inst.read(a, d);
    chk(d, exp);
  endtask
  task automatic push(input logic [15:0] c);
    @(posedge core_clk);
    msg_valid <= 1'b1;
    msg_code <= c;
    @(posedge core_clk);
    msg_valid <= 1'b0;
    msg_code <= ~c;
  endtask
  task automatic flags_chk(input logic [31:0] exp);
    repeat (2) @(posedge core_clk);
    #1;
    chk({29'h0, meas_summary, ques_summary, oper_summary}, exp);
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    err_count++;
    report_and_stop();
  end
  initial begin
    nrst = 1'b0;
    {meas_cond, ques_cond, oper_cond, msg_code} = 64'h0;
    trace_buffer_full_flag = 1'b0;
    msg_valid = 1'b0;
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    rd_chk(8'h4c, 32'h10);
    rd_chk(8'h28, 32'h0);
    rd_chk(8'hfc, 32'h0);
    $display("test reset done");
    @(posedge core_clk);
    meas_cond <= 16'h0021;
    ques_cond <= 16'h4010;
    oper_cond <= 16'h0430;
    trace_buffer_full_flag <= 1'b1;
    repeat (4) @(posedge core_clk);
    rd_chk(8'h00, 32'h0221);
    rd_chk(8'h04, 32'h4010);
    rd_chk(8'h08, 32'h0430);
    host_inst.write(8'h00, 32'hffff);
    rd_chk(8'h00, 32'h0221);
    host_inst.write(8'h18, 32'h0200);
    host_inst.write(8'h20, 32'h0030);
    host_inst.write(8'h1c, 32'h4010);
    rd_chk(8'h1c, 32'h4010);
    flags_chk(32'h7);
    host_inst.write(8'h18, 32'h0000);
    flags_chk(32'h3);
    host_inst.write(8'h24, 32'h0);
    rd_chk(8'h18, 32'h0);
    rd_chk(8'h1c, 32'h0);
    rd_chk(8'h20, 32'h0);
    flags_chk(32'h0);
    rd_chk(8'h0c, 32'h0221);
    rd_chk(8'h04, 32'h4010);
    $display("test status done");
    push(-16'sd110);
    push(16'sd5);
    push(16'sd150);
    rd_chk(8'h4c, 32'h2);
    rd_chk(8'h28, 32'hffff_ff92);
    rd_chk(8'h2c, 32'h5);
    rd_chk(8'h2c, 32'h0);
    for (int i = 1; i <= 12; i++) push(16'(i));
    rd_chk(8'h4c, 32'h2a);
    chk({31'h0, q_overflow}, 32'h1);
    for (int i = 1; i <= 9; i++) rd_chk(8'h28, 32'(i));
    rd_chk(8'h28, 32'h15e);
    rd_chk(8'h28, 32'h0);
    push(16'sd3);
    host_inst.write(8'h30, 32'h0);
    rd_chk(8'h4c, 32'h10);
    $display("test queue done");
    host_inst.write(8'h34, 32'h0);
    push(16'sd7);
    rd_chk(8'h4c, 32'h10);
    host_inst.list_item(8'h38, -16'sd110, -16'sd222);
    host_inst.list_item(8'h38, -16'sd230, -16'sd230);
    host_inst.write(8'h40, 32'hffff_ff74);
    rd_chk(8'h40, 32'hffff_ff74);
    rd_chk(8'h44, 32'h1);
    rd_chk(8'h48, 32'h0);
    push(-16'sd140);
    push(-16'sd231);
    push(-16'sd110);
    push(-16'sd222);
    push(-16'sd230);
    push(16'sd5);
    rd_chk(8'h4c, 32'h4);
    host_inst.list_item(8'h3c, -16'sd140, -16'sd140);
    rd_chk(8'h48, 32'h1);
    push(-16'sd140);
    exp_q = '{32'hffff_ff74, 32'hffff_ff92, 32'hffff_ff22, 32'hffff_ff1a, 32'h0};
    foreach (exp_q[k]) rd_chk(8'h28, exp_q[k]);
    $display("test filter done");
    report_and_stop();
  end
endmodule
